/* File: logic/ncsr_defines.vh */
// Constants for the negate/stack/call/reset execution unit
`ifndef NCSR_DEFINES_VH
`define NCSR_DEFINES_VH
// Register offsets on the AHB-Lite slave
`define NCSR_OFF_CTRL 8'h00
`define NCSR_OFF_INSTR 8'h04
`define NCSR_OFF_WREG 8'h08
`define NCSR_OFF_BANK_SEL 8'h0C
`define NCSR_OFF_STATUS 8'h10
`define NCSR_OFF_PC 8'h14
`define NCSR_OFF_PROD 8'h18
`define NCSR_OFF_STACK_TOP 8'h1C
`define NCSR_OFF_DADDR 8'h20
`define NCSR_OFF_DDATA 8'h24
`define NCSR_OFF_SP 8'h28
// Control register fields
`define NCSR_CTRL_GO 0
`define NCSR_CTRL_BUSY 1
`define NCSR_CTRL_RSTSEEN 2
// Status flag positions
`define NCSR_FLAG_C 0
`define NCSR_FLAG_DIGIT_CARRY 1
`define NCSR_FLAG_Z 2
`define NCSR_FLAG_OVERFLOW 3
`define NCSR_FLAG_N 4
// Opcode patterns
`define NCSR_OP_MUL_HI 7'h01
`define NCSR_OP_NEG_HI 7'h36
`define NCSR_OP_CALL_HI 5'h1B
`define NCSR_OP_POP 16'h0006
`define NCSR_OP_PUSH 16'h0005
`define NCSR_OP_RESET 16'h00FF
// Reset values, access bank split point and PC step
`define NCSR_RST_PC 21'h00_0000
`define NCSR_RST_BYTE 8'h00
`define NCSR_RST_FLAGS 5'h00
`define NCSR_ACCESS_SPLIT 8'h80
`define NCSR_PC_STEP 21'h00_0002
`endif

/* File: logic/ncsr_exec.v */
// Execution unit for multiply, negate, pop, push, relative call and software reset
//
// Notes on behaviour
// - multiply W by file byte into product pair
// - negate file byte, update all five flags
// - negated result written back same cycle
// - a=0 access bank, a=1 bank select register
// - pop discards top entry, flags untouched
// - after pop, previous push becomes top
// - push stores PC+2 on stack top
// - push shifts old top down one level
// - relative call carries 11-bit signed offset
// - call pushes PC+2, jumps PC+2+2n
// - relative call takes two cycles, flags unchanged
// - reset opcode triggers full core reset
// - after reset all registers take reset values; reset seen is set, not cleared
//
// Register map, byte offsets, one aligned word each
//   0x00 control: bit 0 go (write), bit 1 busy (read)
//        bit 2 reset seen (read, write one to clear)
//   0x04 opcode word, 16 bits
//   0x08 working byte
//   0x0C bank select, 4 bits
//   0x10 flags: carry 0, digit carry 1, zero 2
//        overflow 3, negative 4
//   0x14 program counter, 21 bits
//   0x18 product pair, high byte above low byte
//   0x1C stack top, read only, zero when empty
//   0x20 data byte pointer
//   0x24 data byte at the pointer
//   0x28 stack depth, read only
// Unmapped offsets read zero and ignore writes.
//
// Bus timing
//   Zero wait states, response always OKAY.
//   Read data is captured at the address edge,
//   so it stands through the whole data phase.
//   Write data is taken at the data phase edge.
//   Limitation: a read pipelined straight behind a
//   write to the same register sees the old value.
//
// Execution timing
//   Go write lands at the data edge; busy rises there.
//   One execute cycle for every opcode.
//   The call adds one idle cycle, so busy is two long.
//   All writes, control included, are dropped while busy,
//   so a running opcode always sees stable operands.
//
// Storage choices
//   Data memory is 256 bytes; bank number folds into
//   the low byte, so banks alias onto each other.
//   Access bank: low half of bank 0, high of bank 15.
//   Push at full depth is dropped, pop at empty ignored.
//   Software reset keeps the data memory contents.
//
`default_nettype none
`include "ncsr_defines.vh"
module ncsr_exec #(
  parameter DEPTH = 31,
  parameter SPW = 5
) (
  // AHB-Lite clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Core status
  output reg busy_reg_o,
  output reg sw_reset_pulse
);
  // Bus, core state
  reg ph_reg;
  reg ph_wr_reg;
  reg [7:0] ph_addr_reg;
  reg [15:0] instr_reg;
  reg [7:0] wreg_reg;
  reg [3:0] bank_select_register;
  reg [4:0] flags_reg;
  reg [20:0] pc_reg;
  reg [7:0] product_high_byte;
  reg [7:0] product_low_byte;
  reg [SPW-1:0] sp_reg;
  reg [20:0] stack_mem [0:DEPTH-1];
  reg [7:0] data_mem [0:255];
  reg [7:0] daddr_reg;
  reg rstseen_reg;
  // One-hot execution states
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_EXEC = 3'b010;
  localparam [2:0] S_NOP2 = 3'b100;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  integer i;
  // Pointer value at which the stack counts as full
  localparam [SPW-1:0] SP_FULL = DEPTH;

  // Bank resolution: access bank splits low/high halves of banks 0 and 15
  function [11:0] ea;
    input a_bit;
    input [3:0] bank;
    input [7:0] f;
    begin
      if (a_bit)
        ea = {bank, f};
      else if (f < `NCSR_ACCESS_SPLIT)
        ea = {4'h0, f};
      else
        ea = {4'hF, f};
    end
  endfunction

  // Only 256 data bytes are modelled; effective address is folded to them
  wire [11:0] eff = ea(instr_reg[8], bank_select_register, instr_reg[7:0]);
  wire [7:0] eidx = eff[7:0] ^ {4'h0, eff[11:8]};
  wire [7:0] fval = data_mem[eidx];
  wire [7:0] negv = ~fval + 8'h01;
  wire [15:0] prod = wreg_reg * fval;
  wire [4:0] nibs = {1'b0, ~fval[3:0]} + 5'h01;
  wire [8:0] full = {1'b0, ~fval} + 9'h001;
  wire [20:0] pc2 = pc_reg + `NCSR_PC_STEP;
  wire [20:0] offs = {{9{instr_reg[10]}}, instr_reg[10:0], 1'b0};
  wire is_mul = instr_reg[15:9] == `NCSR_OP_MUL_HI;
  wire is_neg = instr_reg[15:9] == `NCSR_OP_NEG_HI;
  wire is_call = instr_reg[15:11] == `NCSR_OP_CALL_HI;
  wire is_pop = instr_reg == `NCSR_OP_POP;
  wire is_push = instr_reg == `NCSR_OP_PUSH;
  wire is_rst = instr_reg == `NCSR_OP_RESET;
  wire [SPW-1:0] sp_top = sp_reg - {{(SPW-1){1'b0}}, 1'b1};

  // Bus handshake qualifiers
  wire ap = hsel & hready & htrans[1];
  wire wr_go = ph_reg & ph_wr_reg & (ph_addr_reg == `NCSR_OFF_CTRL) & hwdata[`NCSR_CTRL_GO];
  wire start = wr_go & (state_reg == S_IDLE);

  // Next state; a reset opcode finishes in its own cycle
  always @* begin
    case (state_reg)
      S_IDLE: state_next = start ? S_EXEC : S_IDLE;
      S_EXEC: state_next = is_call ? S_NOP2 : S_IDLE;
      S_NOP2: state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  // Read mux on the address phase, so data stands in the data phase
  reg [31:0] rd;
  always @* begin
    case (haddr[7:0])
      `NCSR_OFF_CTRL: rd = {29'h0000_0000, rstseen_reg, busy_reg_o, 1'b0};
      `NCSR_OFF_INSTR: rd = {16'h0000, instr_reg};
      `NCSR_OFF_WREG: rd = {24'h00_0000, wreg_reg};
      `NCSR_OFF_BANK_SEL: rd = {28'h000_0000, bank_select_register};
      `NCSR_OFF_STATUS: rd = {27'h000_0000, flags_reg};
      `NCSR_OFF_PC: rd = {11'h000, pc_reg};
      `NCSR_OFF_PROD: rd = {16'h0000, product_high_byte, product_low_byte};
      `NCSR_OFF_STACK_TOP: rd = (sp_reg == {SPW{1'b0}}) ? 32'h0000_0000 : {11'h000, stack_mem[sp_top]};
      `NCSR_OFF_DADDR: rd = {24'h00_0000, daddr_reg};
      `NCSR_OFF_DDATA: rd = {24'h00_0000, data_mem[daddr_reg]};
      `NCSR_OFF_SP: rd = {{(32-SPW){1'b0}}, sp_reg};
      default: rd = 32'h0000_0000;
    endcase
  end

  // Bus slave: zero wait states, always OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_reg <= 1'b0;
      ph_wr_reg <= 1'b0;
      ph_addr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ph_reg <= ap;
      ph_wr_reg <= hwrite;
      ph_addr_reg <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      // Captured at the address edge; holds until the next read
      if (ap & ~hwrite)
        hrdata <= rd;
    end
  end

  // Core state; software reset restores every register and flag except reset seen, which it sets
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= S_IDLE;
      instr_reg <= 16'h0000;
      wreg_reg <= `NCSR_RST_BYTE;
      bank_select_register <= 4'h0;
      flags_reg <= `NCSR_RST_FLAGS;
      pc_reg <= `NCSR_RST_PC;
      product_high_byte <= `NCSR_RST_BYTE;
      product_low_byte <= `NCSR_RST_BYTE;
      sp_reg <= {SPW{1'b0}};
      daddr_reg <= 8'h00;
      rstseen_reg <= 1'b0;
      busy_reg_o <= 1'b0;
      sw_reset_pulse <= 1'b0;
      for (i = 0; i < DEPTH; i = i + 1)
        stack_mem[i] <= 21'h00_0000;
      for (i = 0; i < 256; i = i + 1)
        data_mem[i] <= 8'h00;
    end else begin
      state_reg <= state_next;
      busy_reg_o <= (state_next != S_IDLE);
      sw_reset_pulse <= 1'b0;
      // Register writes only while idle so a running op sees stable operands
      if (ph_reg & ph_wr_reg & (state_reg == S_IDLE)) begin
        case (ph_addr_reg)
          `NCSR_OFF_INSTR: instr_reg <= hwdata[15:0];
          `NCSR_OFF_WREG: wreg_reg <= hwdata[7:0];
          `NCSR_OFF_BANK_SEL: bank_select_register <= hwdata[3:0];
          `NCSR_OFF_STATUS: flags_reg <= hwdata[4:0];
          `NCSR_OFF_PC: pc_reg <= hwdata[20:0];
          `NCSR_OFF_DADDR: daddr_reg <= hwdata[7:0];
          `NCSR_OFF_DDATA: data_mem[daddr_reg] <= hwdata[7:0];
          `NCSR_OFF_CTRL: if (hwdata[`NCSR_CTRL_RSTSEEN]) rstseen_reg <= 1'b0;
          default: ;
        endcase
      end
      if (state_reg == S_EXEC) begin
        if (is_rst) begin
          // Registers to reset values as on external clear, but data and stack memory keep their contents and reset seen is set
          state_reg <= S_IDLE;
          busy_reg_o <= 1'b0;
          sw_reset_pulse <= 1'b1;
          rstseen_reg <= 1'b1;
          instr_reg <= 16'h0000;
          wreg_reg <= `NCSR_RST_BYTE;
          bank_select_register <= 4'h0;
          flags_reg <= `NCSR_RST_FLAGS;
          pc_reg <= `NCSR_RST_PC;
          product_high_byte <= `NCSR_RST_BYTE;
          product_low_byte <= `NCSR_RST_BYTE;
          sp_reg <= {SPW{1'b0}};
          daddr_reg <= 8'h00;
        end else if (is_mul) begin
          product_high_byte <= prod[15:8];
          product_low_byte <= prod[7:0];
          pc_reg <= pc2;
        end else if (is_neg) begin
          data_mem[eidx] <= negv;
          flags_reg[`NCSR_FLAG_N] <= negv[7];
          // Overflow only when the most negative byte negates to itself
          flags_reg[`NCSR_FLAG_OVERFLOW] <= (fval == 8'h80);
          flags_reg[`NCSR_FLAG_C] <= full[8];
          flags_reg[`NCSR_FLAG_DIGIT_CARRY] <= nibs[4];
          flags_reg[`NCSR_FLAG_Z] <= (negv == 8'h00);
          pc_reg <= pc2;
        end else if (is_pop) begin
          // Underflow leaves the pointer at zero
          if (sp_reg != {SPW{1'b0}})
            sp_reg <= sp_top;
          pc_reg <= pc2;
        end else if (is_push | is_call) begin
          // Entries below stay in place, so the old top is one level down
          if (sp_reg != SP_FULL) begin
            stack_mem[sp_reg] <= pc2;
            sp_reg <= sp_reg + {{(SPW-1){1'b0}}, 1'b1};
          end
          // Target counts from the already advanced counter
          pc_reg <= is_call ? pc2 + offs : pc2;
        end else begin
          pc_reg <= pc2;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/ncsr_exec_monitor.sv */
// Assertion checker for the execution unit ports
`default_nettype none
module ncsr_exec_monitor (
  // Clock, reset and bus
  input wire logic hclk, hresetn, hsel, hwrite, hready,
  input wire logic [1:0] htrans,
  input wire logic [31:0] haddr, hwdata,
  // Core status
  input wire logic busy_reg_o, sw_reset_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_ph;
  logic [7:0] ad_ph;
  logic [15:0] ins;
  wire go = wr_ph && ad_ph == 8'h00 && hwdata[0] && !busy_reg_o;
  // Opcode is only visible as bus write data, so shadow it here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
      ad_ph <= 8'h00;
      ins <= 16'h0000;
    end else begin
      wr_ph <= hsel && hready && htrans[1] && hwrite;
      ad_ph <= haddr[7:0];
      if (wr_ph && ad_ph == 8'h04) ins <= hwdata[15:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Call is the only two-cycle operation
  sequence s_two_busy; busy_reg_o [*2] ##1 !busy_reg_o; endsequence
  property p_go; go |-> ##[1:3] busy_reg_o; endproperty
  a_go: assert property (p_go) else $error("start ignored");
  property p_call; $rose(busy_reg_o) && ins[15:11] == 5'h1b |-> s_two_busy; endproperty
  a_call: assert property (p_call) else $error("call length wrong");
  property p_single; $rose(busy_reg_o) && ins[15:11] != 5'h1b |=> !busy_reg_o; endproperty
  a_single: assert property (p_single) else $error("op too long");
  property p_bound; $rose(busy_reg_o) |-> ##[1:2] !busy_reg_o; endproperty
  a_bound: assert property (p_bound) else $error("busy stuck");
  property p_rst; $rose(busy_reg_o) && ins == 16'h00ff |-> ##[0:2] sw_reset_pulse; endproperty
  a_rst: assert property (p_rst) else $error("no reset pulse");
  property p_once; sw_reset_pulse |=> !sw_reset_pulse; endproperty
  a_once: assert property (p_once) else $error("pulse too long");
  property p_none; $rose(busy_reg_o) && ins != 16'h00ff |-> !sw_reset_pulse [*3]; endproperty
  a_none: assert property (p_none) else $error("stray reset");
  property p_idle; sw_reset_pulse |=> !busy_reg_o [*2]; endproperty
  a_idle: assert property (p_idle) else $error("busy after reset");
endmodule
bind ncsr_exec ncsr_exec_monitor ncsr_exec_monitor_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite),
  .hready(hready), .htrans(htrans), .haddr(haddr), .hwdata(hwdata), .busy_reg_o(busy_reg_o),
  .sw_reset_pulse(sw_reset_pulse));
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the execution unit
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] rq;
  wire hready, hreadyout, hresp, busy_reg_o, sw_reset_pulse;
  wire [31:0] hrdata;
  int miscompares = 0;
  int checks = 0;
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  ncsr_exec ncsr_exec_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .busy_reg_o(busy_reg_o), .sw_reset_pulse(sw_reset_pulse));
  initial begin
    forever #50 hclk = ~hclk;
  end
  task automatic print_verdict;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Bounded wait so a dead slave ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      print_verdict;
    end
  endtask
  // One single word transfer; read data lands in rq
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w = 1'b1);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    rq = hrdata;
  endtask
  task automatic rk(input logic [7:0] a, input logic [31:0] e);
    bus(a, 32'h0000_0000, 1'b0);
    chk(rq, e);
  endtask
  // Busy rises at the go data edge and lasts at most two cycles, so skip three cycles before polling
  task automatic run(input logic [15:0] op);
    int n;
    bus(8'h04, {16'h0000, op});
    bus(8'h00, 32'h0000_0001);
    repeat (3) @(posedge hclk);
    n = 0;
    do begin
      bus(8'h00, 32'h0000_0000, 1'b0);
      n++;
    end while (rq[1] !== 1'b0 && n < 20);
    if (rq[1] !== 1'b0) begin
      miscompares++;
      print_verdict;
    end
  endtask
  task automatic t_neg;
    bus(8'h0c, 32'h0000_0005);
    bus(8'h20, 32'h0000_0015);
    bus(8'h24, 32'h0000_0080);
    bus(8'h20, 32'h0000_0010);
    bus(8'h24, 32'h0000_003a);
    run(16'h6c10);
    rk(8'h10, 32'h0000_0010);
    rk(8'h24, 32'h0000_00c6);
    run(16'h6d10);
    rk(8'h10, 32'h0000_001a);
    rk(8'h24, 32'h0000_00c6);
    bus(8'h20, 32'h0000_0015);
    rk(8'h24, 32'h0000_0080);
    bus(8'h24, 32'h0000_0000);
    run(16'h6d10);
    rk(8'h10, 32'h0000_0007);
    $display("negate test done");
  endtask
  task automatic t_mul;
    bus(8'h08, 32'h0000_00c4);
    bus(8'h20, 32'h0000_0020);
    bus(8'h24, 32'h0000_00b5);
    run(16'h0220);
    rk(8'h18, 32'h0000_8a94);
    rk(8'h24, 32'h0000_00b5);
    rk(8'h10, 32'h0000_0007);
    $display("multiply test done");
  endtask
  task automatic t_stack;
    bus(8'h14, 32'h0000_0124);
    run(16'h0005);
    run(16'h0005);
    rk(8'h1c, 32'h0000_0128);
    rk(8'h28, 32'h0000_0002);
    run(16'h0006);
    rk(8'h1c, 32'h0000_0126);
    rk(8'h28, 32'h0000_0001);
    $display("stack test done");
  endtask
  // Both ends of the offset range
  task automatic t_call;
    bus(8'h14, 32'h0000_1000);
    run(16'hdc00);
    rk(8'h14, 32'h0000_0802);
    rk(8'h1c, 32'h0000_1002);
    run(16'hdbff);
    rk(8'h14, 32'h0000_1002);
    rk(8'h28, 32'h0000_0003);
    rk(8'h10, 32'h0000_0007);
    $display("call test done");
  endtask
  task automatic t_reset;
    run(16'h00ff);
    bus(8'h00, 32'h0000_0000, 1'b0);
    chk(rq & 32'h0000_0004, 32'h0000_0004);
    for (int a = 8; a <= 40; a += 4)
      if (a != 36) rk(a[7:0], 32'h0000_0000);
    $display("reset test done");
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_neg;
    t_mul;
    t_stack;
    t_call;
    t_reset;
    print_verdict;
  end
endmodule
`default_nettype wire
